// File: bench/sixteen_bit_timer_counter_bench.sv
// self-checking bench of the sixteen_bit_counter block
`timescale 1ns/1ps
module sixteen_bit_timer_counter_bench;
    import stc_pkg::*;

    typedef struct packed {
        logic [31:0] lo;
        logic [31:0] hi;
    } stc_exp_t;

    logic         i_clk;
    logic         i_srst;
    stc_avs_req_t avs;
    logic [31:0]  rdata;
    logic         wait_req;
    logic         irq;
    logic         pin;
    logic         osc;
    logic         pin_en;
    logic         osc_en;
    logic         lp_ok;
    logic [1:0]   xtal;
    logic [1:0]   pdir;
    logic [1:0]   xtal_rd;
    logic [1:0]   dir_eff;
    logic         osc_run;
    stc_exp_t     exp_q[$];
    stc_exp_t     e;
    int           n_errors;
    int           num_checks;
    int           seed;
    logic [7:0]   rnd;
    logic [4:0]   ofs[6]     = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14};
    logic [7:0]   ext_ctl[5] = '{8'h03, 8'h07, 8'h0B, 8'h0F, 8'h0B};
    logic [7:0]   ext_exp[5] = '{8'h09, 8'h09, 8'h09, 8'h09, 8'h00};

    stc_timer stc_timer_inst (
        .i_clk             (i_clk),
        .i_srst            (i_srst),
        .i_avs             (avs),
        .o_avs_readdata    (rdata),
        .o_avs_waitrequest (wait_req),
        .o_irq             (irq),
        .i_ext_count_in    (pin),
        .i_lposc_clk       (osc),
        .i_sysclk_lp_ok    (lp_ok),
        .i_xtal_pins       (xtal),
        .i_port_a_dir      (pdir),
        .o_xtal_pin_rd     (xtal_rd),
        .o_xtal_dir_eff    (dir_eff),
        .o_lposc_run       (osc_run)
    );

    stc_count_src stc_count_src_inst (
        .i_clk    (i_clk),
        .i_srst   (i_srst),
        .i_pin_en (pin_en),
        .i_osc_en (osc_en),
        .o_pin    (pin),
        .o_osc    (osc)
    );

    // ------------------------------------------------------------
    // clock, compare and closing
    // ------------------------------------------------------------
    initial
    begin
        i_clk = 1'h0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        if (n_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    // hold the request until waitrequest is sampled low, release after it
    task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
        @(posedge i_clk);
        avs.address   <= a;
        avs.read      <= ~w;
        avs.write     <= w;
        avs.writedata <= {24'h000000, d};
        // no cycle count assumed; only the watchdog ends a stuck wait
        do
            @(posedge i_clk);
        while (wait_req !== 1'h0);
        avs.read  <= 1'h0;
        avs.write <= 1'h0;
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(a, 1'h1, d);
    endtask : wr

    // note the expected window first, the monitor compares the answer
    task automatic rd(input logic [4:0] a, input logic [31:0] lo, input logic [31:0] hi);
        exp_q.push_back({lo, hi});
        bus(a, 1'h0, 8'h00);
    endtask : rd

    // take the oldest note whenever a read is answered
    always @(posedge i_clk)
    begin
        if (avs.read && wait_req === 1'h0)
        begin
            e = exp_q.pop_front();
            if (e.lo == e.hi)
                check(rdata, e.lo);
            else
                check({31'h0, rdata >= e.lo && rdata <= e.hi}, 32'h1);
        end
    end

    // watchdog: the sequence needs about 2,900 clocks, allow about seven times that
    initial
    begin
        #200000;
        n_errors++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 32'h73626AB5;
        n_errors = 0;
        num_checks = 0;
        avs = '{5'h00, 1'h0, 1'h0, 32'h0, 4'h1};
        rnd = 8'($random(seed));
        // one bit of each pair fixed so masking is always visible
        xtal = {rnd[1], 1'h1};
        pdir = {1'h0, rnd[2]};
        pin_en = 1'h0;
        osc_en = 1'h0;
        lp_ok = 1'h1;
        i_srst = 1'h1;
        repeat (4) @(posedge i_clk);
        i_srst <= 1'h0;
        foreach (ofs[k]) rd(ofs[k], 32'h0, 32'h0);
        rnd = 8'($random(seed));
        wr(STC_OFS_CTRL, rnd & 8'hFE);
        rd(STC_OFS_CTRL, rnd & STC_CTRL_WMSK & 8'hFE, rnd & STC_CTRL_WMSK & 8'hFE);
        for (int c = 0; c < 4; c++)
        begin
            wr(STC_OFS_CTRL, 8'h00);
            wr(STC_OFS_HIGH, 8'h00);
            wr(STC_OFS_LOW, 8'h00);
            wr(STC_OFS_CTRL, {2'h0, c[1:0], 1'h0, c[0], 2'h1});
            repeat (400) @(posedge i_clk);
            wr(STC_OFS_CTRL, 8'h00);
            rd(STC_OFS_LOW, (100 >> c) - 1, (100 >> c) + 2);
        end
        wr(STC_OFS_LOW, 8'h5A);
        repeat (200) @(posedge i_clk);
        rd(STC_OFS_LOW, 8'h5A, 8'h5A);
        // wide mode: buffered high byte
        wr(STC_OFS_CTRL, 8'h80);
        wr(STC_OFS_HIGH, 8'h12);
        wr(STC_OFS_LOW, 8'h34);
        wr(STC_OFS_HIGH, 8'h77);
        rd(STC_OFS_LOW, 8'h34, 8'h34);
        rd(STC_OFS_HIGH, 8'h12, 8'h12);
        wr(STC_OFS_CTRL, 8'h00);
        rd(STC_OFS_HIGH, 8'h12, 8'h12);
        // wrap, mask and read-to-clear
        wr(STC_OFS_HIGH, 8'hFF);
        wr(STC_OFS_LOW, 8'hF0);
        wr(STC_OFS_MASK, 8'h01);
        wr(STC_OFS_CTRL, 8'h01);
        repeat (100) @(posedge i_clk);
        check(irq, 32'h1);
        wr(STC_OFS_CTRL, 8'h00);
        wr(STC_OFS_MASK, 8'h00);
        repeat (3) @(posedge i_clk);
        check(irq, 32'h0);
        wr(STC_OFS_MASK, 8'h01);
        repeat (3) @(posedge i_clk);
        check(irq, 32'h1);
        rd(STC_OFS_STAT, 32'h1, 32'h1);
        repeat (3) @(posedge i_clk);
        check(irq, 32'h0);
        rd(STC_OFS_STAT, 32'h0, 32'h0);
        // external pin and oscillator, sync and async
        for (int k = 0; k < 5; k++)
        begin
            wr(STC_OFS_CTRL, 8'h00);
            wr(STC_OFS_HIGH, 8'h00);
            wr(STC_OFS_LOW, 8'h00);
            lp_ok <= (k < 4);
            wr(STC_OFS_CTRL, ext_ctl[k]);
            repeat (8) @(posedge i_clk); // oscillator start-up delay
            pin_en <= ~ext_ctl[k][3];
            osc_en <= ext_ctl[k][3];
            repeat (123) @(posedge i_clk);
            pin_en <= 1'h0;
            osc_en <= 1'h0;
            if (ext_ctl[k][3])
                check({xtal_rd, dir_eff, osc_run}, 32'h07);
            repeat (20) @(posedge i_clk);
            wr(STC_OFS_CTRL, 8'h00);
            rd(STC_OFS_LOW, ext_exp[k], ext_exp[k]);
        end
        repeat (5) @(posedge i_clk);
        check({xtal_rd, dir_eff, osc_run}, {xtal, pdir, 1'h0});
        report_and_stop();
    end
endmodule : sixteen_bit_timer_counter_bench

// File: bench/stc_count_src.sv
// count pin and low-power oscillator model driving the counter inputs
`timescale 1ns/1ps
module stc_count_src (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_srst,
    // which source toggles
    input  wire logic i_pin_en,
    input  wire logic i_osc_en,
    // generated levels
    output logic      o_pin,
    output logic      o_osc
);
    logic [2:0] cnt_q;

    // six clocks per half period, so one source period spans three ticks
    always_ff @(posedge i_clk)
    begin
        if (i_srst || !(i_pin_en || i_osc_en))
            cnt_q <= 3'h0;
        else
            cnt_q <= (cnt_q == 3'h5) ? 3'h0 : cnt_q + 3'h1;
    end

    // levels start low; a disabled source stands still
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_pin <= 1'h0;
            o_osc <= 1'h0;
        end
        else if (cnt_q == 3'h5)
        begin
            o_pin <= o_pin ^ i_pin_en;
            o_osc <= o_osc ^ i_osc_en;
        end
    end
endmodule : stc_count_src

// File: hdl/stc_pkg.sv
// constants, field layouts and carrier types of the sixteen_bit_counter block
package stc_pkg;

    // ------------------------------------------------------------
    // register byte offsets on the avalon slave
    // ------------------------------------------------------------
    localparam logic [4:0] STC_OFS_CTRL = 5'h00; // counter_control
    localparam logic [4:0] STC_OFS_LOW  = 5'h04; // count_low_byte
    localparam logic [4:0] STC_OFS_HIGH = 5'h08; // count_high_byte
    localparam logic [4:0] STC_OFS_STAT = 5'h0C; // overflow_flag, read clears
    localparam logic [4:0] STC_OFS_MASK = 5'h10; // overflow_irq_enable

    // ------------------------------------------------------------
    // reset values and counting constants
    // ------------------------------------------------------------
    localparam logic [7:0]  STC_CTRL_RST  = 8'h00;
    localparam logic [15:0] STC_CNT_RST   = 16'h0000;
    localparam logic [15:0] STC_CNT_MAX   = 16'hFFFF;
    localparam logic [1:0]  STC_PHASE_END = 2'h3;  // fosc/4: four clocks per cycle
    localparam logic [7:0]  STC_CTRL_WMSK = 8'hBF; // bit 6 reserved, reads zero

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wide;     // wide_access_mode
        logic       rsv;
        logic [1:0] presc;    // prescale 1:1, 1:2, 1:4, 1:8
        logic       osc_en;   // lowpower_osc_enable
        logic       async;    // 1 = external count not synchronized
        logic       src;      // count_source_select
        logic       run;      // counter_run
    } stc_ctrl_t;

    typedef struct packed {
        logic [4:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } stc_avs_req_t;

    // terminal count of the prescaler for a ratio code
    function automatic logic [2:0] stc_presc_end(input logic [1:0] code);
        unique case (code)
            2'h0: stc_presc_end = 3'h0;
            2'h1: stc_presc_end = 3'h1;
            2'h2: stc_presc_end = 3'h3;
            2'h3: stc_presc_end = 3'h7;
        endcase
    endfunction : stc_presc_end

endpackage : stc_pkg

// File: hdl/stc_timer.sv
// sixteen_bit_counter: timer, synchronous and asynchronous counter with avalon slave
`timescale 1ns/1ps
module stc_timer (
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_srst,
    // avalon-mm slave
    input  wire stc_pkg::stc_avs_req_t i_avs,
    output logic [31:0]               o_avs_readdata,
    output logic                      o_avs_waitrequest,
    // interrupt
    output logic                      o_irq,
    // count pins and clock environment
    input  wire logic                 i_ext_count_in,
    input  wire logic                 i_lposc_clk,
    input  wire logic                 i_sysclk_lp_ok,
    // crystal pin digital path
    input  wire logic [1:0]           i_xtal_pins,
    input  wire logic [1:0]           i_port_a_dir,
    output logic [1:0]                o_xtal_pin_rd,
    output logic [1:0]                o_xtal_dir_eff,
    output logic                      o_lposc_run
);
    import stc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    stc_ctrl_t   ctrl_q;
    logic [15:0] cnt_q;
    logic [7:0]  hbuf_q;
    logic [2:0]  pre_q;
    logic [1:0]  phase_q;
    logic        ovf_q, mask_q;
    logic [3:0]  s1_q, s2_q;
    logic        sel_prev_q, arm_q, pend_q, run_prev_q;
    logic        rd_cap, acc, wr_acc, wr_low, wr_high, wr_cnt;
    logic        sel_lvl, ext_rise, ext_fall, ext_tick, insn_tick;
    logic        src_tick, count_en, inc;

    // ------------------------------------------------------------
    // avalon handshake: one wait cycle, answer on the second edge
    // ------------------------------------------------------------
    // read data and read side effects are taken at the capture edge
    assign rd_cap  = i_avs.read && o_avs_waitrequest;
    assign acc     = (i_avs.read || i_avs.write) && !o_avs_waitrequest;
    assign wr_acc  = acc && i_avs.write && i_avs.byteenable[0];
    assign wr_low  = wr_acc && i_avs.address == STC_OFS_LOW;
    assign wr_high = wr_acc && i_avs.address == STC_OFS_HIGH;
    // in wide mode a high write touches only the buffer and the edge arm
    assign wr_cnt  = wr_low || (wr_high && !ctrl_q.wide);
    // waitrequest drops for exactly the accepting cycle
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_avs_waitrequest <= 1'b1;
        else
            o_avs_waitrequest <= !(o_avs_waitrequest && (i_avs.read || i_avs.write));
    end
    // read mux, unmapped offsets read zero
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_avs_readdata <= 32'h0000_0000;
        else if (rd_cap)
        begin
            unique case (i_avs.address)
                STC_OFS_CTRL: o_avs_readdata <= {24'h00_0000, ctrl_q & STC_CTRL_WMSK};
                STC_OFS_LOW:  o_avs_readdata <= {24'h00_0000, cnt_q[7:0]};
                STC_OFS_HIGH: o_avs_readdata <= {24'h00_0000,
                                 ctrl_q.wide ? hbuf_q : cnt_q[15:8]};
                STC_OFS_STAT: o_avs_readdata <= {31'h0000_0000, ovf_q};
                STC_OFS_MASK: o_avs_readdata <= {31'h0000_0000, mask_q};
                default:      o_avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // control and mask registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            ctrl_q <= STC_CTRL_RST;
        else if (wr_acc && i_avs.address == STC_OFS_CTRL)
            ctrl_q <= i_avs.writedata[7:0] & STC_CTRL_WMSK;
    end
    // mask holds the single overflow enable
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            mask_q <= 1'b0;
        else if (wr_acc && i_avs.address == STC_OFS_MASK)
            mask_q <= i_avs.writedata[0];
    end

    // ------------------------------------------------------------
    // pin synchronizers: ext, osc, two crystal pins
    // ------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            {s2_q, s1_q} <= 8'h00;
        else
            {s2_q, s1_q} <= {s1_q, i_xtal_pins, i_lposc_clk, i_ext_count_in};
    end

    // ------------------------------------------------------------
    // clock source selection and edge detection
    // ------------------------------------------------------------
    // oscillator only feeds the counter with a suitable system clock
    always_comb
    begin
        if (ctrl_q.osc_en)
            sel_lvl = s2_q[1] && i_sysclk_lp_ok;
        else
            sel_lvl = s2_q[0];
    end

    assign ext_rise = sel_lvl && !sel_prev_q;
    assign ext_fall = !sel_lvl && sel_prev_q;
    assign ext_tick = ext_rise && arm_q;
    // last levels for edge and enable detection
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            sel_prev_q <= 1'b0;
            run_prev_q <= 1'b0;
        end
        else
        begin
            sel_prev_q <= sel_lvl;
            run_prev_q <= ctrl_q.run;
        end
    end
    // arm needs a falling edge after enable, disable or count write
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            arm_q <= 1'b0;
        else if (!ctrl_q.run || !run_prev_q || wr_cnt || wr_high)
            arm_q <= 1'b0;
        else if (ext_fall)
            arm_q <= 1'b1;
    end
    // instruction cycle phase, fosc/4
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            phase_q <= 2'h0;
        else
            phase_q <= phase_q + 2'h1;
    end
    assign insn_tick = phase_q == STC_PHASE_END;
    // synchronous counter holds an edge until the next instruction cycle
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            pend_q <= 1'b0;
        else if (insn_tick)
            pend_q <= 1'b0;
        else if (ext_tick)
            pend_q <= 1'b1;
    end
    // three modes; async bit only matters on the external source
    always_comb
    begin
        if (!ctrl_q.src)
            src_tick = insn_tick;
        else if (ctrl_q.async)
            src_tick = ext_tick;
        else
            src_tick = insn_tick && (pend_q || ext_tick);
    end
    assign count_en = ctrl_q.run && src_tick && !wr_cnt;
    assign inc      = count_en && pre_q == stc_presc_end(ctrl_q.presc);

    // ------------------------------------------------------------
    // prescaler and counter pair
    // ------------------------------------------------------------
    // only low writes clear the prescaler
    always_ff @(posedge i_clk)
    begin
        if (i_srst || wr_low)
            pre_q <= 3'h0;
        else if (inc)
            pre_q <= 3'h0;
        else if (count_en)
            pre_q <= pre_q + 3'h1;
    end
    // a count write wins over an increment in the same cycle
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            cnt_q <= STC_CNT_RST;
        else if (wr_low)
            cnt_q <= {ctrl_q.wide ? hbuf_q : cnt_q[15:8],
                      i_avs.writedata[7:0]};
        else if (wr_high && !ctrl_q.wide)
            cnt_q <= {i_avs.writedata[7:0], cnt_q[7:0]};
        else if (inc)
            cnt_q <= cnt_q + 16'h0001;
    end
    // high byte buffer: snapshot on low read, loaded by high write
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            hbuf_q <= 8'h00;
        else if (wr_high && ctrl_q.wide)
            hbuf_q <= i_avs.writedata[7:0];
        else if (rd_cap && ctrl_q.wide && i_avs.address == STC_OFS_LOW)
            hbuf_q <= cnt_q[15:8];
    end

    // ------------------------------------------------------------
    // overflow flag and interrupt
    // ------------------------------------------------------------
    // read clears only what was reported; a new wrap wins
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            ovf_q <= 1'b0;
        else if (inc && cnt_q == STC_CNT_MAX)
            ovf_q <= 1'b1;
        else if (rd_cap && i_avs.address == STC_OFS_STAT)
            ovf_q <= 1'b0;
    end
    // level interrupt, one clock behind the flag
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_irq <= 1'b0;
        else
            o_irq <= ovf_q && mask_q;
    end

    // ------------------------------------------------------------
    // crystal pins and oscillator run
    // ------------------------------------------------------------
    // oscillator owns the pins: digital path off, directions ignored
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_xtal_pin_rd  <= 2'h0;
            o_xtal_dir_eff <= 2'h3;
            o_lposc_run    <= 1'b0;
        end
        else
        begin
            o_xtal_pin_rd  <= ctrl_q.osc_en ? 2'h0 : s2_q[3:2];
            o_xtal_dir_eff <= ctrl_q.osc_en ? 2'h3 : i_port_a_dir;
            o_lposc_run    <= ctrl_q.osc_en;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    property p_int_rate;
        count_en && !ctrl_q.src |=> !count_en [*3];
    endproperty
    a_int_rate: assert property (p_int_rate) else $error("internal count too fast");
    property p_hold;
        !ctrl_q.run && !wr_cnt |=> cnt_q == $past(cnt_q);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved while stopped");
    property p_wrap;
        inc && cnt_q == STC_CNT_MAX |=> cnt_q == STC_CNT_RST && ovf_q;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap or overflow flag wrong");
    property p_irq;
        ovf_q && mask_q |=> o_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");
    property p_presc;
        wr_low |=> pre_q == 3'h0;
    endproperty
    a_presc: assert property (p_presc) else $error("prescaler not cleared");
    property p_presc_keep;
        wr_high && !count_en |=> pre_q == $past(pre_q);
    endproperty
    a_presc_keep: assert property (p_presc_keep) else $error("high write moved prescaler");
    property p_snap;
        rd_cap && ctrl_q.wide && i_avs.address == STC_OFS_LOW
            |=> hbuf_q == $past(cnt_q[15:8]);
    endproperty
    a_snap: assert property (p_snap) else $error("high byte not snapshot");
    property p_commit;
        wr_low && ctrl_q.wide
            |=> cnt_q == {$past(hbuf_q), $past(i_avs.writedata[7:0])};
    endproperty
    a_commit: assert property (p_commit) else $error("wide write not committed");
    property p_arm;
        wr_cnt ##1 !ext_fall |-> ##1 !ext_tick;
    endproperty
    a_arm: assert property (p_arm) else $error("edge counted without fall");
    property p_pins;
        ctrl_q.osc_en |=> o_xtal_pin_rd == 2'h0 && o_xtal_dir_eff == 2'h3;
    endproperty
    a_pins: assert property (p_pins) else $error("crystal pins not masked");
    property p_lp_ok;
        ctrl_q.osc_en && !i_sysclk_lp_ok |-> !ext_rise;
    endproperty
    a_lp_ok: assert property (p_lp_ok) else $error("oscillator used without lp clock");
    property p_ack;
        (i_avs.read || i_avs.write) && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer not in one cycle");

endmodule : stc_timer
